// ==== design/fsw_consts.vh ====
// Constants for the fail-safe supervision unit
`ifndef FSW_CONSTS_VH
`define FSW_CONSTS_VH

// Supervision counter layout
`define FSW_CNT_W 15
`define FSW_RELOAD_W 7
`define FSW_LOW_CLR_W 8
`define FSW_CNT_MAX 15'h7FFF

// Prescaler chain: base divide, fixed divide-by-two, selectable divide-by-16
`define FSW_BASE_DIV 6
`define FSW_DIV2 2
`define FSW_DIV16 16

// Rate select encoding
`define FSW_RATE_DIV12 1'b0
`define FSW_RATE_DIV192 1'b1

// Clock rate and oscillator monitor timing
`define FSW_CLK_MHZ 250
`define FSW_FINAL_DELAY_US 1000
`define FSW_FINAL_DELAY_CYC (`FSW_FINAL_DELAY_US * `FSW_CLK_MHZ)
`define FSW_MON_WINDOW 16
`define FSW_MON_CNT_W 8

// Length of the internal reset pulse after a supervision overflow
`define FSW_RST_HOLD_CYC 16

`endif

// ==== design/fsw_osc_monitor.v ====
// Oscillator monitor: compares on-chip and RC oscillator, holds reset on failure
`default_nettype none
`include "fsw_consts.vh"

module fsw_osc_monitor #(
  parameter FINAL_CYC = `FSW_FINAL_DELAY_CYC,
  parameter WINDOW = `FSW_MON_WINDOW
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire osc_clk_i,
  input wire rc_clk_i,
  output reg clk_sel_rc_o,
  output reg osc_reset_o,
  output reg osc_good_o
);
  localparam [2:0] S_HOLD = 3'h1;
  localparam [2:0] S_SETTLE = 3'h2;
  localparam [2:0] S_RUN = 3'h4;
  localparam integer WIN_I = WINDOW;
  localparam [`FSW_MON_CNT_W-1:0] WIN = WIN_I[`FSW_MON_CNT_W-1:0];

  reg [2:0] osc_sync;
  reg [2:0] rc_sync;
  reg [`FSW_MON_CNT_W-1:0] osc_cnt;
  reg [`FSW_MON_CNT_W-1:0] rc_cnt;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] settle_cnt;
  reg win_done;
  reg win_fast;

  wire osc_rise = osc_sync[1] & ~osc_sync[2];
  wire rc_rise = rc_sync[1] & ~rc_sync[2];

  // Bit 0 feeds only bit 1; edges are taken from bits 1 and 2
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      osc_sync <= 3'h0;
      rc_sync <= 3'h0;
    end else begin
      osc_sync <= {osc_sync[1:0], osc_clk_i};
      rc_sync <= {rc_sync[1:0], rc_clk_i};
    end
  end

  // Count on-chip edges over a window of RC edges; never gated off
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      osc_cnt <= {`FSW_MON_CNT_W{1'b0}};
      rc_cnt <= {`FSW_MON_CNT_W{1'b0}};
      win_done <= 1'b0;
      win_fast <= 1'b0;
    end else begin
      win_done <= 1'b0;
      if (rc_rise && rc_cnt == WIN - 8'h01) begin
        win_done <= 1'b1;
        win_fast <= (osc_cnt + {7'h00, osc_rise}) > WIN;
        rc_cnt <= {`FSW_MON_CNT_W{1'b0}};
        osc_cnt <= {`FSW_MON_CNT_W{1'b0}};
      end else begin
        if (rc_rise)
          rc_cnt <= rc_cnt + 8'h01;
        if (osc_rise && osc_cnt != 8'hFF)
          osc_cnt <= osc_cnt + 8'h01;
      end
    end
  end

  always @* begin
    next_state = state;
    case (state)
      S_HOLD: begin
        if (win_done && win_fast)
          next_state = S_SETTLE;
      end
      S_SETTLE: begin
        if (win_done && !win_fast)
          next_state = S_HOLD;
        else if (settle_cnt >= FINAL_CYC - 1)
          next_state = S_RUN;
      end
      S_RUN: begin
        if (win_done && !win_fast)
          next_state = S_HOLD;
      end
      default: next_state = S_HOLD;
    endcase
  end

  // Power-on starts in hold, clocked from RC until the oscillator is proven
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= S_HOLD;
      settle_cnt <= 32'h0;
      clk_sel_rc_o <= 1'b1;
      osc_reset_o <= 1'b1;
      osc_good_o <= 1'b0;
    end else begin
      state <= next_state;
      settle_cnt <= (next_state == S_SETTLE && state == S_SETTLE) ?
                    settle_cnt + 32'h1 : 32'h0;
      clk_sel_rc_o <= (next_state != S_RUN);
      osc_reset_o <= (next_state != S_RUN);
      osc_good_o <= (next_state != S_HOLD);
    end
  end
endmodule
`default_nettype wire

// ==== design/fsw_top.v ====
// Fail-safe supervision unit: software supervision counter and oscillator monitor
// How it works
// - 15-bit up-counter, one step per tick
// - Ticks via divide-by-two then selectable divide-by-16
// - Software picks clock/12 or clock/192 rate
// - Software programs period via upper seven bits
// - Period 192 us to 393.2 ms at 16 MHz
// - Start bit starts counter; only a reset stops it
// - Overflow without refresh forces internal reset
// - Refresh loads reload value into upper bits
// - Refresh only on arm then start, back-to-back
// - Flag tells overflow reset from external reset
// - Counter frozen in idle and power-down
// - Slow oscillator: switch to RC, hold reset
// - Oscillator recovered: about 1 ms, then release
// - RC clock drives reset sequence after power-on
// - Oscillator monitor always on, no disable
`default_nettype none
`include "fsw_consts.vh"

module fsw_top #(
  parameter FINAL_CYC = `FSW_FINAL_DELAY_CYC,
  parameter MON_WINDOW = `FSW_MON_WINDOW,
  parameter BASE_DIV = `FSW_BASE_DIV,
  parameter RST_HOLD_CYC = `FSW_RST_HOLD_CYC
) (
  input wire clk_i,
  input wire sys_rst_i,
  input wire ext_rst_n_i,
  input wire osc_clk_i,
  input wire rc_clk_i,
  input wire instr_end_i,
  input wire refresh_arm_bit_i,
  input wire supervisor_start_bit_i,
  input wire [`FSW_RELOAD_W-1:0] supervisor_reload_value_i,
  input wire rate_sel_i,
  input wire idle_mode_i,
  input wire power_down_i,
  output reg [`FSW_CNT_W-1:0] sup_count_o,
  output reg sup_running_o,
  output reg sup_reset_o,
  output reg supervisor_reset_cause_flag_o,
  output reg refresh_ok_o,
  output wire clk_sel_rc_o,
  output wire osc_reset_o,
  output wire osc_good_o
);
  localparam integer BASE_LAST_I = BASE_DIV - 1;
  localparam integer DIV16_LAST_I = `FSW_DIV16 - 1;
  localparam integer HOLD_LAST_I = RST_HOLD_CYC - 1;
  localparam [3:0] BASE_LAST = BASE_LAST_I[3:0];
  localparam [4:0] DIV16_LAST = DIV16_LAST_I[4:0];
  localparam [4:0] HOLD_LAST = HOLD_LAST_I[4:0];

  reg [1:0] ext_rst_sync;
  reg [3:0] base_cnt;
  reg div2_ph;
  reg [4:0] div16_cnt;
  reg tick;
  reg armed;
  reg armed_now;
  reg [4:0] hold_cnt;

  wire frozen = idle_mode_i | power_down_i;
  wire ext_rst_active = ~ext_rst_sync[1];
  wire refresh = supervisor_start_bit_i & armed;
  // A refresh landing on the last count still counts as in time
  wire overflow = sup_running_o & tick & ~frozen & ~refresh &
                  (sup_count_o == `FSW_CNT_MAX);
  wire int_reset = sup_reset_o | osc_reset_o | ext_rst_active;

  // External reset pin is asynchronous to clk_i
  always @(posedge clk_i) begin
    if (sys_rst_i)
      ext_rst_sync <= 2'h3;
    else
      ext_rst_sync <= {ext_rst_sync[0], ext_rst_n_i};
  end

  // Base divide, then /2, then optional /16: clock/12 or clock/192
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      base_cnt <= 4'h0;
      div2_ph <= 1'b0;
      div16_cnt <= 5'h00;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!frozen) begin
        if (base_cnt == BASE_LAST) begin
          base_cnt <= 4'h0;
          div2_ph <= ~div2_ph;
          if (div2_ph) begin
            if (rate_sel_i == `FSW_RATE_DIV12) begin
              tick <= 1'b1;
            end else if (div16_cnt == DIV16_LAST) begin
              div16_cnt <= 5'h00;
              tick <= 1'b1;
            end else begin
              div16_cnt <= div16_cnt + 5'h01;
            end
          end
        end else begin
          base_cnt <= base_cnt + 4'h1;
        end
      end
    end
  end

  // Arm survives exactly to the end of the following instruction
  always @(posedge clk_i) begin
    if (sys_rst_i || int_reset) begin
      armed <= 1'b0;
      armed_now <= 1'b0;
    end else if (refresh_arm_bit_i) begin
      armed <= 1'b1;
      armed_now <= instr_end_i ? 1'b0 : 1'b1;
    end else if (refresh) begin
      armed <= 1'b0;
      armed_now <= 1'b0;
    end else if (instr_end_i) begin
      if (armed_now)
        armed_now <= 1'b0;
      else
        armed <= 1'b0;
    end
  end

  // Counter: starts once, cannot be stopped except by a reset
  always @(posedge clk_i) begin
    if (sys_rst_i || int_reset) begin
      sup_running_o <= 1'b0;
      sup_count_o <= {`FSW_CNT_W{1'b0}};
      refresh_ok_o <= 1'b0;
    end else begin
      refresh_ok_o <= refresh;
      if (supervisor_start_bit_i)
        sup_running_o <= 1'b1;
      if (refresh) begin
        sup_count_o <= {supervisor_reload_value_i,
                        {`FSW_LOW_CLR_W{1'b0}}};
      end else if (sup_running_o && tick && !frozen) begin
        sup_count_o <= sup_count_o + 15'h0001;
      end
    end
  end

  // Internal reset pulse after overflow; held long enough to clear the core
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      sup_reset_o <= 1'b0;
      hold_cnt <= 5'h00;
    end else if (overflow) begin
      sup_reset_o <= 1'b1;
      hold_cnt <= 5'h00;
    end else if (sup_reset_o) begin
      if (hold_cnt == HOLD_LAST)
        sup_reset_o <= 1'b0;
      else
        hold_cnt <= hold_cnt + 5'h01;
    end
  end

  // Cause flag: overflow sets, external reset clears; set wins
  always @(posedge clk_i) begin
    if (sys_rst_i)
      supervisor_reset_cause_flag_o <= 1'b0;
    else if (overflow)
      supervisor_reset_cause_flag_o <= 1'b1;
    else if (ext_rst_active)
      supervisor_reset_cause_flag_o <= 1'b0;
  end

  // No enable input exists: the monitor cannot be switched off
  fsw_osc_monitor #(
    .FINAL_CYC(FINAL_CYC),
    .WINDOW(MON_WINDOW)
  ) u_osc_monitor (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .osc_clk_i(osc_clk_i),
    .rc_clk_i(rc_clk_i),
    .clk_sel_rc_o(clk_sel_rc_o),
    .osc_reset_o(osc_reset_o),
    .osc_good_o(osc_good_o)
  );
endmodule
`default_nettype wire

// ==== verif/fsw_top_props.sv ====
// Concurrent checks on the supervision unit ports
`default_nettype none
`include "fsw_consts.vh"
module fsw_top_props (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ext_rst_n_i,
  input wire logic instr_end_i,
  input wire logic refresh_arm_bit_i,
  input wire logic supervisor_start_bit_i,
  input wire logic [`FSW_RELOAD_W-1:0] supervisor_reload_value_i,
  input wire logic idle_mode_i,
  input wire logic power_down_i,
  input wire logic [`FSW_CNT_W-1:0] sup_count_o,
  input wire logic sup_running_o,
  input wire logic sup_reset_o,
  input wire logic supervisor_reset_cause_flag_o,
  input wire logic refresh_ok_o,
  input wire logic clk_sel_rc_o,
  input wire logic osc_reset_o,
  input wire logic osc_good_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic frz = idle_mode_i || power_down_i;
  wire logic calm = !sup_reset_o && !osc_reset_o;
  sequence ext_s; ext_rst_n_i[*3]; endsequence
  sequence arm_s; refresh_arm_bit_i && instr_end_i ##1 supervisor_start_bit_i && calm; endsequence
  step_count_a: assert property ($changed(sup_count_o) |-> sup_count_o ==
    $past(sup_count_o) + 15'h0001 || refresh_ok_o || sup_count_o == 15'h0000) else $error("bad step");
  freeze_hold_a: assert property ((frz && !supervisor_start_bit_i)[*2] |=>
    $stable(sup_count_o) || sup_count_o == 15'h0000) else $error("count moved while frozen");
  refresh_load_a: assert property (ext_s ##0 arm_s |=> refresh_ok_o &&
    sup_count_o == {supervisor_reload_value_i, 8'h00}) else $error("refresh not taken");
  stray_ok_a: assert property (refresh_ok_o |-> $past(supervisor_start_bit_i))
    else $error("refresh without start");
  no_stop_a: assert property (ext_s ##0 (sup_running_o && calm) |=> sup_running_o)
    else $error("counter stopped");
  ovf_cause_a: assert property ($rose(sup_reset_o) |-> $past(sup_count_o) == 15'h7FFF)
    else $error("reset without overflow");
  rst_hold_a: assert property ($rose(sup_reset_o) |-> sup_reset_o[*8])
    else $error("reset too short");
  rst_effect_a: assert property ($rose(sup_reset_o) |-> ##2 supervisor_reset_cause_flag_o
    && !sup_running_o && sup_count_o == 15'h0000) else $error("overflow effect missing");
  flag_clear_a: assert property ((!ext_rst_n_i)[*4] |-> !supervisor_reset_cause_flag_o)
    else $error("cause flag kept");
  osc_pair_a: assert property (clk_sel_rc_o == osc_reset_o)
    else $error("clock select and reset differ");
  settle_gap_a: assert property ($fell(osc_reset_o) |-> $past(osc_good_o, 8))
    else $error("released before settling");
endmodule
`default_nettype wire

// ==== verif/fsw_top_bench.sv ====
// Directed testbench for the supervision unit
`default_nettype none
`include "fsw_consts.vh"
module fsw_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, sys_rst_i = 1, ext_rst_n_i = 1, osc_clk_i = 0, rc_clk_i = 0;
  logic instr_end_i = 0, refresh_arm_bit_i = 0, supervisor_start_bit_i = 0;
  logic rate_sel_i = 0, idle_mode_i = 0, power_down_i = 0, osc_dead = 0;
  logic [`FSW_RELOAD_W-1:0] supervisor_reload_value_i = 7'h7F;
  wire [`FSW_CNT_W-1:0] sup_count_o;
  wire sup_running_o, sup_reset_o, supervisor_reset_cause_flag_o, refresh_ok_o;
  wire clk_sel_rc_o, osc_reset_o, osc_good_o;
  int err_count = 0, checks_done = 0;
  logic [7:0] div = 0;
  logic [`FSW_CNT_W-1:0] snap, d;
  fsw_top #(.FINAL_CYC(50), .MON_WINDOW(4)) dut (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ext_rst_n_i(ext_rst_n_i),
    .osc_clk_i(osc_clk_i),
    .rc_clk_i(rc_clk_i),
    .instr_end_i(instr_end_i),
    .refresh_arm_bit_i(refresh_arm_bit_i),
    .supervisor_start_bit_i(supervisor_start_bit_i),
    .supervisor_reload_value_i(supervisor_reload_value_i),
    .rate_sel_i(rate_sel_i),
    .idle_mode_i(idle_mode_i),
    .power_down_i(power_down_i),
    .sup_count_o(sup_count_o),
    .sup_running_o(sup_running_o),
    .sup_reset_o(sup_reset_o),
    .supervisor_reset_cause_flag_o(supervisor_reset_cause_flag_o),
    .refresh_ok_o(refresh_ok_o),
    .clk_sel_rc_o(clk_sel_rc_o),
    .osc_reset_o(osc_reset_o),
    .osc_good_o(osc_good_o)
  );
  initial forever #2 clk_i = ~clk_i;
  // On-chip oscillator four times the RC rate, both far below clk
  always @(posedge clk_i) begin
    div <= div + 8'h01;
    if (div[1:0] == 2'h3 && !osc_dead) osc_clk_i <= ~osc_clk_i;
    if (div[3:0] == 4'hF) rc_clk_i <= ~rc_clk_i;
  end
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic osc_up;
    for (int i = 0; i < 3000 && osc_reset_o !== 0; i++) cyc(1);
    chk("osc run", {osc_reset_o, clk_sel_rc_o, osc_good_o}, 3'b001);
  endtask
  // Gap puts a second instruction end between arm and start
  task automatic refresh(input bit gap);
    cyc(1);
    refresh_arm_bit_i <= 1;
    instr_end_i <= 1;
    cyc(1);
    refresh_arm_bit_i <= 0;
    instr_end_i <= gap;
    if (gap) begin
      cyc(1);
      instr_end_i <= 0;
    end
    supervisor_start_bit_i <= 1;
    cyc(1);
    supervisor_start_bit_i <= 0;
    @(negedge clk_i);
    chk("ok", refresh_ok_o, !gap);
    if (!gap) chk("load", sup_count_o, {supervisor_reload_value_i, 8'h00});
  endtask
  task automatic t_start;
    cyc(1);
    supervisor_start_bit_i <= 1;
    cyc(1);
    supervisor_start_bit_i <= 0;
    @(negedge clk_i);
    chk("run", sup_running_o, 1);
    chk("no ok", refresh_ok_o, 0);
  endtask
  task automatic rate(input bit sel, input int n, input int k);
    cyc(1);
    rate_sel_i <= sel;
    snap = sup_count_o;
    cyc(n);
    d = sup_count_o - snap;
    chk("rate", d >= k - 1 && d <= k + 1, 1);
  endtask
  initial begin
    cyc(16);
    sys_rst_i <= 0;
    cyc(1);
    chk("rc boot", clk_sel_rc_o, 1);
    osc_up();
    t_start();
    refresh(1);
    refresh(0);
    rate(0, 120, 10);
    rate(1, 576, 3);
    rate(0, 36, 3);
    for (int m = 0; m < 2; m++) begin
      {idle_mode_i, power_down_i} <= m ? 2'b01 : 2'b10;
      cyc(2);
      snap = sup_count_o;
      cyc(100);
      chk("frozen", sup_count_o, snap);
      {idle_mode_i, power_down_i} <= 2'b00;
      cyc(1);
    end
    for (int i = 0; i < 4000 && sup_reset_o !== 1; i++) cyc(1);
    chk("ovf", sup_reset_o, 1);
    cyc(3);
    chk("after ovf", {supervisor_reset_cause_flag_o, sup_running_o, sup_count_o}, 17'h10000);
    cyc(20);
    ext_rst_n_i <= 0;
    cyc(5);
    chk("ext flag", supervisor_reset_cause_flag_o, 0);
    ext_rst_n_i <= 1;
    cyc(4);
    t_start();
    osc_dead <= 1;
    for (int i = 0; i < 1000 && osc_reset_o !== 1; i++) cyc(1);
    cyc(2);
    chk("osc fail", {osc_reset_o, clk_sel_rc_o, sup_running_o}, 3'b110);
    osc_dead <= 0;
    osc_up();
    results();
  end
  initial begin
    #100us;
    err_count++;
    results();
  end
endmodule
bind fsw_top fsw_top_props u_props (
  .clk_i(clk_i),
  .sys_rst_i(sys_rst_i),
  .ext_rst_n_i(ext_rst_n_i),
  .instr_end_i(instr_end_i),
  .refresh_arm_bit_i(refresh_arm_bit_i),
  .supervisor_start_bit_i(supervisor_start_bit_i),
  .supervisor_reload_value_i(supervisor_reload_value_i),
  .idle_mode_i(idle_mode_i),
  .power_down_i(power_down_i),
  .sup_count_o(sup_count_o),
  .sup_running_o(sup_running_o),
  .sup_reset_o(sup_reset_o),
  .supervisor_reset_cause_flag_o(supervisor_reset_cause_flag_o),
  .refresh_ok_o(refresh_ok_o),
  .clk_sel_rc_o(clk_sel_rc_o),
  .osc_reset_o(osc_reset_o),
  .osc_good_o(osc_good_o)
);
`default_nettype wire
